// ---- logic/divider_defines.svh ----
/*
 Offsets, field positions, reset values and timing counts for the encoder
 pulse divider output. Assumes a 40 MHz core clock and a 32-bit AXI4-Lite bus.
*/
`ifndef DIVIDER_DEFINES_SVH
`define DIVIDER_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_PHASE_POLARITY 16'h2542
`define IDX_INDEX_WIDTH 16'h2543
`define IDX_SOURCE_SELECT 16'h2544
`define ADDR_PHASE_POLARITY 16'h9508
`define ADDR_INDEX_WIDTH 16'h950c
`define ADDR_SOURCE_SELECT 16'h9510
`define ADDR_DIVIDE_RATIO 16'h9600
`define ADDR_RESTART 16'h9604
`define ADDR_STATUS 16'h9608

// Reset values
`define RST_PHASE_POLARITY 16'h0000
`define RST_INDEX_WIDTH 16'h0000
`define RST_SOURCE_SELECT 16'h0000
`define RST_DIVIDE_RATIO 16'h0001

// Ranges and fields
`define POL_INDEX_BIT 0
`define POL_A_BIT 1
`define POL_B_BIT 2
`define POLARITY_MAX 16'h0007
`define INDEX_WIDTH_MAX 16'h01f4
`define SOURCE_MAX 16'h0004
`define RESTART_BIT 0

// Timing
`define CLK_PERIOD_NS 25
`define US_IN_NS 1000
`define CYCLES_PER_US ((`US_IN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- logic/divider_pkg.sv ----
/*
 Types shared by the encoder pulse divider output.
 Assumes divider_defines.svh supplies the numeric constants.
*/
package divider_pkg;

	typedef enum logic [2:0] {
		SRC_MOTOR_ENCODER,
		SRC_EXTERNAL_ENCODER,
		SRC_RESERVED,
		SRC_COMMAND_RELAY,
		SRC_DISABLED
	} source_t;

	typedef enum logic [1:0] {
		DIR_NONE,
		DIR_UP,
		DIR_DOWN
	} step_t;

endpackage

// ---- logic/index_stretch.sv ----
/*
 Index pulse shaper: holds the pulse for one A/B cycle plus an extra time.
 Assumes trigger is a one-cycle pulse on the core clock.
*/
`timescale 1ns/1ps
`include "divider_defines.svh"

module index_stretch (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control
	input wire logic trigger,
	input wire logic [23:0] cycle_len,
	input wire logic [8:0] extra_us,
	// Result
	output logic pulse
);
	logic [24:0] remaining;
	logic [24:0] extra_cycles;

	assign extra_cycles = 25'(extra_us) * 25'(`CYCLES_PER_US);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			remaining <= 25'h0000000;
		end else if (trigger) begin
			// One A/B cycle, at least one clock, plus the extension
			remaining <= ((cycle_len == 24'h000000) ? 25'h0000001 : 25'(cycle_len)) + extra_cycles;
		end else if (remaining != 25'h0000000) begin
			remaining <= remaining - 25'h0000001;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse <= 1'b0;
		end else begin
			pulse <= trigger || (remaining > 25'h0000001);
		end
	end
endmodule

// ---- logic/encoder_pulse_divider_output.sv ----
/*
 Encoder pulse divider output: selects a quadrature source, divides it,
 drives A/B/Z or position-comparison levels, with an AXI4-Lite register file.
 Assumes source pins are asynchronous and comparison inputs are on MCLK.
*/
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "divider_defines.svh"

module encoder_pulse_divider_output (
	// Clock and reset
	input wire logic MCLK,
	input wire logic NRST,
	// AXI4-Lite write
	input wire logic [15:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [15:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Quadrature sources: {Z,B,A} of motor, external, command pulses
	input wire logic [2:0] MOTOR_ABZ,
	input wire logic [2:0] EXT_ABZ,
	input wire logic [2:0] CMD_ABZ,
	// Position comparison from drive logic
	input wire logic CMP_SELECT,
	input wire logic CMP_A,
	input wire logic CMP_B,
	input wire logic CMP_Z,
	// Divider outputs
	output logic OUT_A,
	output logic OUT_B,
	output logic OUT_Z
);
	import divider_pkg::*;

	logic [15:0] phase_polarity;
	logic [15:0] index_width;
	logic [15:0] source_select;
	logic [15:0] divide_ratio;
	logic [2:0] act_polarity;
	logic [8:0] act_width;
	source_t act_source;
	logic [15:0] act_ratio;
	logic restart;
	logic [15:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic [8:0] sync1;
	logic [8:0] sync2;
	logic [2:0] sel_abz;
	logic [1:0] prev_ab;
	logic prev_z;
	step_t step;
	logic [15:0] acc_up;
	logic [15:0] acc_down;
	logic [1:0] quad;
	logic [23:0] period_cnt;
	logic [23:0] cycle_len;
	logic index_pulse;
	logic cmp_offered;
	logic next_a;
	logic next_b;
	logic next_z;
	logic [1:0] wr_resp;
	logic [31:0] rd_data;
	logic [1:0] rd_resp;

	// Input synchronisers, two stages per pin
	genvar g;
	generate
		for (g = 0; g < 9; g++) begin : gen_sync
			always_ff @(posedge MCLK or negedge NRST) begin
				if (!NRST) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
				end else begin
					sync1[g] <= (g < 3) ? MOTOR_ABZ[g % 3] : (g < 6) ? EXT_ABZ[g % 3] : CMD_ABZ[g % 3];
					sync2[g] <= sync1[g];
				end
			end
		end
	endgenerate

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// AXI write channel capture, either order
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			aw_held <= 1'b0;
			aw_addr <= 16'h0000;
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end else if (aw_held && w_held) begin
				aw_held <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_held <= 1'b1;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end else if (aw_held && w_held) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
		end else begin
			AWREADY <= !aw_held && !(AWVALID && AWREADY) && !BVALID;
			WREADY <= !w_held && !(WVALID && WREADY) && !BVALID;
		end
	end

	// Register writes; out-of-range values are refused
	always_comb begin
		wr_resp = `RESP_OKAY;
		case (aw_addr)
			`ADDR_PHASE_POLARITY: wr_resp = (merge(phase_polarity, w_data, w_strb) > `POLARITY_MAX) ? `RESP_SLVERR : `RESP_OKAY;
			`ADDR_INDEX_WIDTH: wr_resp = (merge(index_width, w_data, w_strb) > `INDEX_WIDTH_MAX) ? `RESP_SLVERR : `RESP_OKAY;
			`ADDR_SOURCE_SELECT: wr_resp = (merge(source_select, w_data, w_strb) > `SOURCE_MAX) ? `RESP_SLVERR : `RESP_OKAY;
			`ADDR_DIVIDE_RATIO, `ADDR_RESTART: wr_resp = `RESP_OKAY;
			default: wr_resp = `RESP_SLVERR;
		endcase
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			phase_polarity <= `RST_PHASE_POLARITY;
			index_width <= `RST_INDEX_WIDTH;
			source_select <= `RST_SOURCE_SELECT;
			divide_ratio <= `RST_DIVIDE_RATIO;
			restart <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= `RESP_OKAY;
		end else begin
			restart <= 1'b0;
			if (aw_held && w_held) begin
				BVALID <= 1'b1;
				BRESP <= wr_resp;
				if (wr_resp == `RESP_OKAY) begin
					case (aw_addr)
						`ADDR_PHASE_POLARITY: phase_polarity <= merge(phase_polarity, w_data, w_strb);
						`ADDR_INDEX_WIDTH: index_width <= merge(index_width, w_data, w_strb);
						`ADDR_SOURCE_SELECT: source_select <= merge(source_select, w_data, w_strb);
						`ADDR_DIVIDE_RATIO: divide_ratio <= merge(divide_ratio, w_data, w_strb);
						`ADDR_RESTART: restart <= w_strb[0] && w_data[`RESTART_BIT];
						default: restart <= 1'b0;
					endcase
				end
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// Working settings, loaded only at reset or restart
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			act_polarity <= 3'(`RST_PHASE_POLARITY);
			act_width <= 9'(`RST_INDEX_WIDTH);
			act_source <= SRC_MOTOR_ENCODER;
			act_ratio <= `RST_DIVIDE_RATIO;
		end else if (restart) begin
			act_polarity <= phase_polarity[2:0];
			act_width <= index_width[8:0];
			act_source <= source_t'(source_select[2:0]);
			act_ratio <= (divide_ratio == 16'h0000) ? 16'h0001 : divide_ratio;
		end
	end

	// AXI read
	always_comb begin
		rd_data = 32'h00000000;
		rd_resp = `RESP_OKAY;
		case (ARADDR)
			`ADDR_PHASE_POLARITY: rd_data = {16'h0000, phase_polarity};
			`ADDR_INDEX_WIDTH: rd_data = {16'h0000, index_width};
			`ADDR_SOURCE_SELECT: rd_data = {16'h0000, source_select};
			`ADDR_DIVIDE_RATIO: rd_data = {16'h0000, divide_ratio};
			`ADDR_RESTART: rd_data = 32'h00000000;
			`ADDR_STATUS: rd_data = {21'h000000, OUT_Z, OUT_B, OUT_A, cmp_offered, act_source, 1'b0, act_polarity};
			default: rd_resp = `RESP_SLVERR;
		endcase
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `RESP_OKAY;
		end else begin
			ARREADY <= !RVALID && !(ARVALID && ARREADY);
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA <= rd_data;
				RRESP <= rd_resp;
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// Source selection and quadrature step decode
	always_comb begin
		case (act_source)
			SRC_MOTOR_ENCODER: sel_abz = sync2[2:0];
			SRC_EXTERNAL_ENCODER: sel_abz = sync2[5:3];
			SRC_COMMAND_RELAY: sel_abz = sync2[8:6];
			default: sel_abz = 3'b000;
		endcase
		case ({prev_ab, sel_abz[1:0]})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: step = DIR_UP;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: step = DIR_DOWN;
			default: step = DIR_NONE;
		endcase
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			prev_ab <= 2'b00;
			prev_z <= 1'b0;
		end else begin
			prev_ab <= sel_abz[1:0];
			prev_z <= sel_abz[2];
		end
	end

	// Divider: one output step per act_ratio input steps
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			acc_up <= 16'h0000;
			acc_down <= 16'h0000;
			quad <= 2'b00;
		end else if (restart) begin
			acc_up <= 16'h0000;
			acc_down <= 16'h0000;
		end else if (step == DIR_UP) begin
			acc_down <= 16'h0000;
			if (acc_up + 16'h0001 >= act_ratio) begin
				acc_up <= 16'h0000;
				quad <= quad + 2'b01;
			end else begin
				acc_up <= acc_up + 16'h0001;
			end
		end else if (step == DIR_DOWN) begin
			acc_up <= 16'h0000;
			if (acc_down + 16'h0001 >= act_ratio) begin
				acc_down <= 16'h0000;
				quad <= quad - 2'b01;
			end else begin
				acc_down <= acc_down + 16'h0001;
			end
		end
	end

	// Measure the output A/B cycle between rising edges of A
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			period_cnt <= 24'h000000;
			cycle_len <= 24'h000000;
		end else if (next_a && !OUT_A && !cmp_offered) begin
			period_cnt <= 24'h000001;
			cycle_len <= period_cnt;
		end else if (period_cnt != 24'hffffff) begin
			period_cnt <= period_cnt + 24'h000001;
		end
	end

	index_stretch u_index (
		.clk(MCLK),
		.nrst(NRST),
		.trigger(sel_abz[2] && !prev_z),
		.cycle_len(cycle_len),
		.extra_us(act_width),
		.pulse(index_pulse)
	);

	// Output selection
	assign cmp_offered = CMP_SELECT && (act_source == SRC_MOTOR_ENCODER || act_source == SRC_EXTERNAL_ENCODER);

	always_comb begin
		next_a = quad[0] ^ quad[1];
		next_b = quad[1];
		next_z = index_pulse ^ act_polarity[`POL_INDEX_BIT];
		if (act_source == SRC_DISABLED || act_source == SRC_RESERVED) begin
			next_a = 1'b0;
			next_b = 1'b0;
			next_z = 1'b0;
		end else if (cmp_offered) begin
			next_a = CMP_A ^ act_polarity[`POL_A_BIT];
			next_b = CMP_B ^ act_polarity[`POL_B_BIT];
			next_z = CMP_Z ^ act_polarity[`POL_INDEX_BIT];
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			OUT_A <= 1'b0;
			OUT_B <= 1'b0;
			OUT_Z <= 1'b0;
		end else begin
			OUT_A <= next_a;
			OUT_B <= next_b;
			OUT_Z <= next_z;
		end
	end
endmodule

// ---- bench/epdo_assertions.sv ----
/*
 Bus-side checks for the pulse divider.
 Assumes it is bound to the top module's ports.
*/
`timescale 1ns/1ps
`include "divider_defines.svh"
module epdo_checker (
	// Clock and reset
	input wire logic MCLK,
	input wire logic NRST,
	// Write channels
	input wire logic [15:0] AWADDR,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	// Read channels
	input wire logic [15:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	input wire logic RREADY
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!NRST);
	a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped");
	a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped");
	a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read not answered");
	a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
		else $error("write not answered");
	a_aw_drop: assert property (AWVALID && AWREADY |=> !AWREADY)
		else $error("address ready stayed high");
	a_unmapped_read: assert property (ARVALID && ARREADY && ARADDR == 16'h0 |=>
		RRESP == `RESP_SLVERR && RDATA == 32'h0)
		else $error("unmapped read accepted");
	a_source_range: assert property (AWVALID && AWREADY && WVALID && WREADY &&
		AWADDR == `ADDR_SOURCE_SELECT && WDATA[15:0] > `SOURCE_MAX |-> ##[1:2] (BVALID && BRESP == `RESP_SLVERR))
		else $error("bad source accepted");
	a_upper_zero: assert property (RVALID |-> RDATA[31:16] == 16'h0)
		else $error("upper read bits set");
endmodule
bind encoder_pulse_divider_output epdo_checker epdo_checker_inst (.MCLK(MCLK), .NRST(NRST),
	.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WVALID(WVALID),
	.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
	.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

// ---- bench/host_counter.sv ----
/*
 Host model: counts quadrature steps on the divided outputs.
 Assumes positive A/B polarity outside comparison use.
*/
`timescale 1ns/1ps
module host_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Divided phases
	input wire logic a,
	input wire logic b,
	// Position total
	output int pos
);
	logic [1:0] last;
	// One gray step up or down; a skipped state is not counted
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			last <= 2'h0;
			pos <= 0;
		end else begin
			last <= {a, b};
			if ({a, b} == {last[0], ~last[1]}) pos <= pos + 1;
			else if ({a, b} == {~last[0], last[1]}) pos <= pos - 1;
		end
	end
endmodule

// ---- bench/encoder_pulse_divider_output_tb.sv ----
/*
 Self-checking bench for the encoder pulse divider output.
 Assumes the design, checker and host model are compiled first.
*/
`timescale 1ns/1ps
`include "divider_defines.svh"
module encoder_pulse_divider_output_tb;
	logic MCLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, CMP_SELECT, CMP_A, CMP_B, CMP_Z;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, OUT_A, OUT_B, OUT_Z, zinv;
	logic [15:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [1:0] BRESP, RRESP, ph;
	logic [2:0] MOTOR_ABZ, EXT_ABZ, CMD_ABZ;
	int n_errors, check_count, pos, zc, zw;
	localparam int H = 8;
	localparam logic [1:0] OK = `RESP_OKAY;
	localparam logic [1:0] ER = `RESP_SLVERR;
	encoder_pulse_divider_output encoder_pulse_divider_output_inst (.MCLK(MCLK), .NRST(NRST),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY), .MOTOR_ABZ(MOTOR_ABZ), .EXT_ABZ(EXT_ABZ),
		.CMD_ABZ(CMD_ABZ), .CMP_SELECT(CMP_SELECT), .CMP_A(CMP_A), .CMP_B(CMP_B),
		.CMP_Z(CMP_Z), .OUT_A(OUT_A), .OUT_B(OUT_B), .OUT_Z(OUT_Z));
	host_counter host_counter_inst (.clk(MCLK), .nrst(NRST), .a(OUT_A), .b(OUT_B), .pos(pos));
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	// Width of each index pulse, measured against its idle level
	always @(posedge MCLK) begin
		if (OUT_Z ^ zinv) zc <= zc + 1;
		else if (zc != 0) begin
			zw <= zc;
			zc <= 0;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (!BVALID);
		BREADY <= 1'b0;
		chk(BRESP, er);
	endtask
	task rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (ARREADY) ARVALID <= 1'b0;
		end while (!RVALID);
		RREADY <= 1'b0;
		chk(RDATA, ed);
		chk(RRESP, er);
	endtask
	task setup(input logic [15:0] p, input logic [15:0] w, input logic [15:0] s);
		wr(`ADDR_PHASE_POLARITY, p, OK);
		wr(`ADDR_INDEX_WIDTH, w, OK);
		wr(`ADDR_SOURCE_SELECT, s, OK);
		wr(`ADDR_RESTART, 32'h1, OK);
		repeat (8) @(posedge MCLK);
	endtask
	task step(input int src, input logic [1:0] dir, input logic z);
		logic [2:0] v;
		ph = ph + dir;
		v = {z, ph[1] ^ ph[0], ph[1]};
		@(posedge MCLK);
		if (src == 1) EXT_ABZ <= v;
		else if (src == 3) CMD_ABZ <= v;
		else MOTOR_ABZ <= v;
		repeat (H - 1) @(posedge MCLK);
	endtask
	// Forward then back by the same count; the host sees n steps, then home
	task count(input int src);
		int p0, n;
		p0 = pos;
		n = 4 * ($urandom % 4 + 2);
		for (int i = 0; i < n; i++) step(src, 2'h1, 1'b0);
		repeat (8) @(posedge MCLK);
		chk((pos > p0) ? pos - p0 : p0 - pos, n);
		for (int i = 0; i < n; i++) step(src, 2'h3, 1'b0);
		repeat (8) @(posedge MCLK);
		chk(pos - p0, 0);
	endtask
	task ztest(input logic [15:0] w, input logic inv);
		setup({15'h0, inv}, w, 16'h0);
		zinv = inv;
		repeat (4) @(posedge MCLK);
		zw = 0;
		for (int i = 0; i < 12; i++) step(0, 2'h1, i == 8);
		repeat (w * `CYCLES_PER_US + 8 * H) @(posedge MCLK);
		chk(zw, 4 * H + w * `CYCLES_PER_US);
	endtask
	task cmp(input logic [2:0] p, input logic [15:0] s);
		logic [2:0] o;
		setup({13'h0, p}, 16'h0, s);
		o = {OUT_Z, OUT_B, OUT_A};
		for (int i = 0; i < 6; i++) begin
			@(posedge MCLK);
			{CMP_Z, CMP_B, CMP_A} <= 3'($urandom);
			CMP_SELECT <= 1'b1;
			repeat (3) @(posedge MCLK);
			chk({OUT_Z, OUT_B, OUT_A}, s == 0 ? {CMP_Z, CMP_B, CMP_A} ^ {p[0], p[2], p[1]} : o);
		end
		CMP_SELECT <= 1'b0;
	endtask
	initial begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, CMP_SELECT, CMP_A, CMP_B, CMP_Z} = 9'h0;
		{AWADDR, ARADDR, WDATA} = 64'h0;
		{MOTOR_ABZ, EXT_ABZ, CMD_ABZ} = 9'h0;
		ph = 2'h0;
		zinv = 1'b0;
		NRST = 1'b0;
		void'($urandom(32'h7fa80673));
		repeat (10) @(posedge MCLK);
		NRST <= 1'b1;
		rd(`ADDR_PHASE_POLARITY, 32'h0, OK);
		rd(`ADDR_INDEX_WIDTH, 32'h0, OK);
		rd(`ADDR_SOURCE_SELECT, 32'h0, OK);
		rd(16'h0, 32'h0, ER);
		rd(`ADDR_DIVIDE_RATIO, `RST_DIVIDE_RATIO, OK);
		rd(`ADDR_STATUS, 32'h0, OK);
		wr(`ADDR_SOURCE_SELECT, 32'h5, ER);
		wr(`ADDR_INDEX_WIDTH, 32'h1f5, ER);
		wr(`ADDR_PHASE_POLARITY, 32'h8, ER);
		for (int s = 0; s < 5; s++) begin
			wr(`ADDR_SOURCE_SELECT, s, OK);
			rd(`ADDR_SOURCE_SELECT, s, OK);
		end
		count(0);
		setup(16'h0, 16'h0, 16'h1);
		count(1);
		for (int s = 2; s < 5; s += 2) begin
			setup(16'h0, 16'h0, s);
			for (int i = 0; i < 8; i++) begin
				step(0, 2'h1, i == 4);
				chk({OUT_Z, OUT_B, OUT_A}, 3'h0);
			end
		end
		cmp(3'h7, 16'h0);
		cmp(3'($urandom), 16'h0);
		cmp(3'h6, 16'h3);
		ztest(16'h0, 1'b0);
		ztest(16'($urandom % 3 + 1), 1'b0);
		ztest(16'h1f4, 1'b1);
		end_of_test;
	end
	initial begin
		repeat (90000) @(posedge MCLK);
		n_errors++;
		end_of_test;
	end
endmodule
